//--- shared/pcs_pkg.sv
/*
 Package for the codec serial port: timing constants, code words, carriers.
 Assumes a 125 MHz system clock; link pins are asynchronous to it.
*/
package pcs_pkg;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int unsigned CLK_MHZ          = 125;
   localparam int unsigned PDN_QUAL_US      = 1000;
   localparam int unsigned PDN_QUAL_CYCLES  = PDN_QUAL_US * CLK_MHZ;
   // Sync idle watchdog: two nominal frames of 125 us
   localparam int unsigned SYNC_IDLE_US     = 250;
   localparam int unsigned SYNC_IDLE_CYCLES = SYNC_IDLE_US * CLK_MHZ;

   // ------------------------------------------------------------
   // Word layout
   // ------------------------------------------------------------
   localparam int unsigned WORD_BITS = 8;
   localparam int unsigned BIT_CNT_W = 4;
   localparam logic [3:0]  BIT_LAST  = 4'h7;
   localparam logic [3:0]  BIT_IDLE  = 4'h8;
   localparam logic [3:0]  BIT_FIRST = 4'h0;
   // Pin idle levels: test select and power-down rest high
   localparam logic [5:0]  PIN_IDLE  = 6'h30;

   // ------------------------------------------------------------
   // Companded code values
   // ------------------------------------------------------------
   localparam logic [7:0] ALAW_POS_FULL  = 8'hAA;
   localparam logic [7:0] ALAW_POS_ZERO  = 8'hD5;
   localparam logic [7:0] ALAW_NEG_FULL  = 8'h2A;
   localparam logic [7:0] ULAW_POS_FULL  = 8'h80;
   localparam logic [7:0] ULAW_POS_ZERO  = 8'hFF;
   localparam logic [7:0] ULAW_NEG_FULL  = 8'h00;

   typedef enum logic [1:0] {
      PCS_LAW_MU = 2'h1,
      PCS_LAW_A  = 2'h2
   } pcs_law_type;

   // Sample word with its decode hint
   typedef struct packed {
      logic       half_shift;
      logic [7:0] code;
   } pcs_word_type;

   // Section power state
   typedef struct packed {
      logic chip_down;
      logic tx_down;
      logic rx_down;
   } pcs_power_type;

endpackage : pcs_pkg

//--- src/pcs_fifo.sv
/*
 Small flip-flop FIFO with valid/ready on both sides.
 Assumes a single clock and an asynchronous active-low reset.
*/
`timescale 1ns/100ps
`default_nettype none
module pcs_fifo #(
   parameter int unsigned WIDTH = 9,
   parameter int unsigned DEPTH = 4
) (
   input  wire  logic             clk,
   input  wire  logic             rst_n,
   input  wire  logic [WIDTH-1:0] in_data,
   input  wire  logic             in_valid,
   output logic                   in_ready,
   output logic [WIDTH-1:0]       out_data,
   output logic                   out_valid,
   input  wire  logic             out_ready
);
   localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0]    wr_q;
   logic [AW-1:0]    rd_q;
   logic [AW:0]      cnt_q;
   wire              push = in_valid && in_ready;
   wire              pop  = out_valid && out_ready;

   logic [AW:0]      cnt_d;
   logic             ready_q;
   assign cnt_d     = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
   // Ready comes from a flop so the port output stays registered
   assign in_ready  = ready_q;
   assign out_valid = (cnt_q != '0);
   assign out_data  = mem_q[rd_q];

   // ------------------------------------------------------------
   // Pointers
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
         ready_q <= 1'b1;
      end else begin
         if (push) begin
            wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
         end
         cnt_q   <= cnt_d;
         ready_q <= (cnt_d != (AW+1)'(DEPTH));
      end
   end

   // ------------------------------------------------------------
   // Storage
   // ------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < DEPTH; g++) begin : g_ent
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               mem_q[g] <= '0;
            end else if (push && wr_q == AW'(g)) begin
               mem_q[g] <= in_data;
            end
         end
      end
   endgenerate
endmodule : pcs_fifo
`default_nettype wire

//--- src/pcs_serial_port.sv
/*
 Digital serial side of a single-channel companding codec: transmit and
 receive PCM ports, sync and pin power-down, half-bit decode shift and
 loopback select. Assumes all link pins are asynchronous to clk, which
 is at least 8 times faster than either bit clock.
*/
`timescale 1ns/100ps
`default_nettype none

module pcs_serial_port #(
   parameter pcs_pkg::pcs_law_type LAW   = pcs_pkg::PCS_LAW_A,
   parameter int unsigned     PDN_CYCLES = pcs_pkg::PDN_QUAL_CYCLES,
   parameter int unsigned     IDLE_CYCLES = pcs_pkg::SYNC_IDLE_CYCLES,
   parameter int unsigned     FIFO_DEPTH = 4
) (
   input  wire  logic       clk,
   input  wire  logic       rst_n,
   input  wire  logic       tx_bit_clock,
   input  wire  logic       tx_frame_sync,
   input  wire  logic       rx_bit_clock,
   input  wire  logic       rx_frame_sync,
   input  wire  logic       serial_code_in,
   input  wire  logic       powerdown_halfbit_shift,
   input  wire  logic       loopback_test_select,
   output logic             serial_code_out_o,
   output logic             serial_code_out_oe,
   input  wire  logic [7:0] enc_code,
   input  wire  logic       enc_valid,
   output logic             enc_ready,
   output logic [7:0]       dec_code,
   output logic             dec_half_shift,
   output logic             dec_valid,
   output logic             tx_powered_down,
   output logic             rx_powered_down,
   output logic             chip_powered_down,
   output logic             analog_out_enable,
   output logic             analog_in_connect,
   output logic             analog_loopback
);
   localparam int unsigned CW = $clog2(PDN_CYCLES + 1);
   localparam int unsigned IW = $clog2(IDLE_CYCLES + 1);
   localparam int unsigned NP = 6;

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   logic [NP-1:0] pin_raw;
   logic [NP-1:0] s1_q;
   logic [NP-1:0] s2_q;
   logic [NP-1:0] s3_q;
   logic [NP-1:0] pin_q;
   logic [NP-1:0] pin_d;
   assign pin_raw = {loopback_test_select, powerdown_halfbit_shift, serial_code_in,
                     rx_frame_sync, tx_frame_sync, rx_bit_clock};

   // Tx clock runs through its own chain of flops; rx clock stays in the pin vector
   logic       txc_s1_q;
   logic       txc_s2_q;
   logic       txc_s3_q;
   logic       txc_q;

   genvar g;
   generate
      for (g = 0; g < NP; g++) begin : g_sync
         // Change accepted only when second and third stages agree
         assign pin_d[g] = (s2_q[g] == s3_q[g]) ? s3_q[g] : pin_q[g];
      end
   endgenerate

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         // Idle levels avoid a false power-down edge after reset
         s1_q     <= pcs_pkg::PIN_IDLE;
         s2_q     <= pcs_pkg::PIN_IDLE;
         s3_q     <= pcs_pkg::PIN_IDLE;
         pin_q    <= pcs_pkg::PIN_IDLE;
         txc_s1_q <= 1'b0;
         txc_s2_q <= 1'b0;
         txc_s3_q <= 1'b0;
         txc_q    <= 1'b0;
      end else begin
         s1_q     <= pin_raw;
         s2_q     <= s1_q;
         s3_q     <= s2_q;
         pin_q    <= pin_d;
         txc_s1_q <= tx_bit_clock;
         txc_s2_q <= txc_s1_q;
         txc_s3_q <= txc_s2_q;
         txc_q    <= (txc_s2_q == txc_s3_q) ? txc_s3_q : txc_q;
      end
   end

   wire rxc_now = pin_d[0];
   wire txs_now = pin_d[1];
   wire rxs_now = pin_d[2];
   wire din_now = pin_d[3];
   wire pdn_now = pin_d[4];
   wire tmc_now = pin_d[5];
   wire txc_now = (txc_s2_q == txc_s3_q) ? txc_s3_q : txc_q;

   wire txc_rise = txc_now && !txc_q;
   wire txc_fall = !txc_now && txc_q;
   wire rxc_fall = !rxc_now && pin_q[0];
   wire txs_rise = txs_now && !pin_q[1];
   wire rxs_rise = rxs_now && !pin_q[2];
   wire pdn_edge = pdn_now != pin_q[4];

   // ------------------------------------------------------------
   // Power-down detection
   // ------------------------------------------------------------
   logic [IW-1:0] txs_idle_q;
   logic [IW-1:0] rxs_idle_q;
   logic [CW-1:0] pdn_cnt_q;
   pcs_pkg::pcs_power_type pwr_q;
   pcs_pkg::pcs_power_type pwr_d;

   // A sync that stops toggling at either level starves its watchdog
   wire txs_dead = (txs_idle_q == IW'(IDLE_CYCLES));
   wire rxs_dead = (rxs_idle_q == IW'(IDLE_CYCLES));
   wire pdn_long = (pdn_cnt_q == CW'(PDN_CYCLES));

   assign pwr_d.tx_down   = txs_dead;
   assign pwr_d.rx_down   = rxs_dead;
   assign pwr_d.chip_down = pdn_long;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         txs_idle_q <= '0;
         rxs_idle_q <= '0;
         pdn_cnt_q  <= '0;
         pwr_q      <= '0;
      end else begin
         txs_idle_q <= txs_rise ? '0 : (txs_dead ? txs_idle_q : txs_idle_q + 1'b1);
         rxs_idle_q <= rxs_rise ? '0 : (rxs_dead ? rxs_idle_q : rxs_idle_q + 1'b1);
         pdn_cnt_q  <= pdn_now ? '0 : (pdn_long ? pdn_cnt_q : pdn_cnt_q + 1'b1);
         pwr_q      <= pwr_d;
      end
   end

   wire tx_run = !pwr_q.tx_down && !pwr_q.chip_down;
   wire rx_run = !pwr_q.rx_down && !pwr_q.chip_down;

   // ------------------------------------------------------------
   // Transmit path
   // ------------------------------------------------------------
   pcs_pkg::pcs_word_type tx_in;
   pcs_pkg::pcs_word_type tx_head;
   logic                  tx_head_valid;
   logic                  tx_pop;
   assign tx_in.half_shift = 1'b0;
   assign tx_in.code       = enc_code;

   // Back-pressure: encoder stalls while the buffer is full
   pcs_fifo #(
      .WIDTH ($bits(pcs_pkg::pcs_word_type)),
      .DEPTH (FIFO_DEPTH)
   ) u_tx_fifo (
      .clk       (clk),
      .rst_n     (rst_n),
      .in_data   (tx_in),
      .in_valid  (enc_valid),
      .in_ready  (enc_ready),
      .out_data  (tx_head),
      .out_valid (tx_head_valid),
      .out_ready (tx_pop)
   );

   logic [7:0] tx_sh_q;
   logic [3:0] tx_bit_q;
   logic       txs_arm_q;
   logic       out_q;
   logic       oe_q;

   // Idle channel sends positive zero when buffer ran dry
   wire [7:0] zero_code = (LAW == pcs_pkg::PCS_LAW_A) ?
                          pcs_pkg::ALAW_POS_ZERO : pcs_pkg::ULAW_POS_ZERO;
   wire [7:0] tx_word   = tx_head_valid ? tx_head.code : zero_code;
   wire       tx_start  = tx_run && txs_arm_q && txc_rise;
   wire       tx_active = (tx_bit_q != pcs_pkg::BIT_IDLE);
   assign tx_pop = tx_start && tx_head_valid;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_sh_q   <= '0;
         tx_bit_q  <= pcs_pkg::BIT_IDLE;
         txs_arm_q <= 1'b0;
         out_q     <= 1'b0;
         oe_q      <= 1'b0;
      end else begin
         // Sync seen high arms the first clock edge of the frame
         txs_arm_q <= txs_rise ? 1'b1 : (tx_start ? 1'b0 : txs_arm_q);
         if (!tx_run) begin
            tx_bit_q <= pcs_pkg::BIT_IDLE;
            oe_q     <= 1'b0;
         end else if (tx_start) begin
            tx_sh_q  <= {tx_word[6:0], 1'b0};
            tx_bit_q <= pcs_pkg::BIT_FIRST;
            oe_q     <= !tx_word[7];
         end else if (txc_rise && tx_active) begin
            if (tx_bit_q == pcs_pkg::BIT_LAST) begin
               tx_bit_q <= pcs_pkg::BIT_IDLE;
               oe_q     <= 1'b0;
            end else begin
               tx_bit_q <= tx_bit_q + 4'h1;
               tx_sh_q  <= {tx_sh_q[6:0], 1'b0};
               oe_q     <= !tx_sh_q[7];
            end
         end
         out_q <= 1'b0;
      end
   end

   assign serial_code_out_o  = out_q;
   assign serial_code_out_oe = oe_q;

   // ------------------------------------------------------------
   // Receive path
   // ------------------------------------------------------------
   logic [7:0] rx_sh_q;
   logic [3:0] rx_bit_q;
   logic       rxs_arm_q;
   logic [7:0] dec_q;
   logic       dec_v_q;
   logic       half_q;
   logic       half_flag_q;

   wire rx_take = rx_run && rxc_fall && (rxs_arm_q || rx_bit_q != pcs_pkg::BIT_IDLE);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_sh_q     <= '0;
         rx_bit_q    <= pcs_pkg::BIT_IDLE;
         rxs_arm_q   <= 1'b0;
         dec_q       <= '0;
         dec_v_q     <= 1'b0;
         half_q      <= 1'b0;
         half_flag_q <= 1'b0;
      end else begin
         rxs_arm_q <= rxs_rise ? 1'b1 : (rx_take ? 1'b0 : rxs_arm_q);
         dec_v_q   <= 1'b0;
         // In mu-law mode any level change on the pin flips the shift state
         if (pdn_edge && LAW == pcs_pkg::PCS_LAW_MU) begin
            half_q <= !half_q;
         end
         if (!rx_run) begin
            rx_bit_q <= pcs_pkg::BIT_IDLE;
         end else if (rx_take) begin
            rx_sh_q  <= {rx_sh_q[6:0], din_now};
            rx_bit_q <= (rx_bit_q == pcs_pkg::BIT_IDLE) ? 4'h1 :
                        ((rx_bit_q == pcs_pkg::BIT_LAST) ? pcs_pkg::BIT_IDLE
                                                         : rx_bit_q + 4'h1);
            if (rx_bit_q == pcs_pkg::BIT_LAST) begin
               dec_q       <= {rx_sh_q[6:0], din_now};
               dec_v_q     <= 1'b1;
               half_flag_q <= half_q;
            end
         end
      end
   end

   assign dec_code       = dec_q;
   assign dec_valid      = dec_v_q;
   assign dec_half_shift = half_flag_q;

   // ------------------------------------------------------------
   // Power and analog mode outputs
   // ------------------------------------------------------------
   logic tx_pd_q;
   logic rx_pd_q;
   logic chip_pd_q;
   logic analog_voice_out_en_q;
   logic ain_con_q;
   logic loop_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_pd_q   <= 1'b1;
         rx_pd_q   <= 1'b1;
         chip_pd_q <= 1'b0;
         analog_voice_out_en_q <= 1'b0;
         ain_con_q <= 1'b0;
         loop_q    <= 1'b0;
      end else begin
         tx_pd_q   <= !tx_run;
         rx_pd_q   <= !rx_run;
         chip_pd_q <= pwr_q.chip_down;
         analog_voice_out_en_q <= tmc_now && rx_run;
         ain_con_q <= tmc_now;
         loop_q    <= !tmc_now;
      end
   end

   assign tx_powered_down   = tx_pd_q;
   assign rx_powered_down   = rx_pd_q;
   assign chip_powered_down = chip_pd_q;
   assign analog_out_enable = analog_voice_out_en_q;
   assign analog_in_connect = ain_con_q;
   assign analog_loopback   = loop_q;
endmodule : pcs_serial_port
`default_nettype wire

//--- verification/pcs_serial_port_monitor.sv
/* Concurrent checks on the codec serial port pins.
   Assumes a bind into every pcs_serial_port instance. */
`timescale 1ns/100ps
`default_nettype none
module pcs_serial_port_monitor #(
   parameter int unsigned PDN_CYCLES  = 50,
   parameter int unsigned IDLE_CYCLES = 400
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic tx_bit_clock,
   input wire logic tx_frame_sync,
   input wire logic rx_bit_clock,
   input wire logic rx_frame_sync,
   input wire logic powerdown_halfbit_shift,
   input wire logic loopback_test_select,
   input wire logic serial_code_out_o,
   input wire logic serial_code_out_oe,
   input wire logic dec_valid,
   input wire logic tx_powered_down,
   input wire logic rx_powered_down,
   input wire logic chip_powered_down,
   input wire logic analog_out_enable,
   input wire logic analog_in_connect,
   input wire logic analog_loopback
);
   // ------------
   // Counters
   // ------------
   // Raw pins, so counts lead the synchronised view inside the port
   logic [31:0] low_q, txi_q, rxi_q, rise_q;
   logic [3:0]  fall_q;
   logic [3:0]  pin_q;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         {low_q, txi_q, rxi_q, rise_q} <= '0;
         {fall_q, pin_q} <= 8'h00;
      end else begin
         low_q  <= powerdown_halfbit_shift ? 32'h0 : low_q + 32'h1;
         txi_q  <= (tx_frame_sync != pin_q[3]) ? 32'h0 : txi_q + 32'h1;
         rxi_q  <= (rx_frame_sync != pin_q[2]) ? 32'h0 : rxi_q + 32'h1;
         rise_q <= (tx_bit_clock && !pin_q[1]) ? 32'h0 : rise_q + 32'h1;
         if (rx_frame_sync && !pin_q[2]) begin
            fall_q <= 4'h0;
         end else if (!rx_bit_clock && pin_q[0] && fall_q != 4'hF) begin
            fall_q <= fall_q + 4'h1;
         end
         pin_q <= {tx_frame_sync, rx_frame_sync, tx_bit_clock, rx_bit_clock};
      end
   end
   // ------------
   // Properties
   // ------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_drain_only: assert property (serial_code_out_o == 1'b0)
      else $error("Serial output drove high");
   a_quiet_down: assert property (tx_powered_down [*2] |-> !serial_code_out_oe)
      else $error("Output active while transmit down");
   a_out_after_rise: assert property ($changed(serial_code_out_oe) |-> rise_q <= 32'd10)
      else $error("Output moved away from a clock rise");
   a_rx_word_count: assert property ($rose(dec_valid) |-> fall_q == 4'h8)
      else $error("Word not after eight falls");
   a_pin_qualify: assert property ($rose(chip_powered_down) |-> low_q >= PDN_CYCLES)
      else $error("Chip down too early");
   a_tx_idle_down: assert property (txi_q == IDLE_CYCLES + 10 |-> tx_powered_down)
      else $error("Transmit not down on static sync");
   a_rx_idle_down: assert property (rxi_q == IDLE_CYCLES + 10 |-> rx_powered_down)
      else $error("Receive not down on static sync");
   a_loop_select: assert property ((!loopback_test_select) [*6] |->
      analog_loopback && !analog_out_enable && !analog_in_connect)
      else $error("Loopback paths wrong");
endmodule : pcs_serial_port_monitor

bind pcs_serial_port pcs_serial_port_monitor #(
   .PDN_CYCLES(PDN_CYCLES), .IDLE_CYCLES(IDLE_CYCLES)
) mon_u (.clk(clk), .rst_n(rst_n), .tx_bit_clock(tx_bit_clock),
   .tx_frame_sync(tx_frame_sync), .rx_bit_clock(rx_bit_clock),
   .rx_frame_sync(rx_frame_sync), .powerdown_halfbit_shift(powerdown_halfbit_shift),
   .loopback_test_select(loopback_test_select), .serial_code_out_o(serial_code_out_o),
   .serial_code_out_oe(serial_code_out_oe), .dec_valid(dec_valid),
   .tx_powered_down(tx_powered_down), .rx_powered_down(rx_powered_down),
   .chip_powered_down(chip_powered_down), .analog_out_enable(analog_out_enable),
   .analog_in_connect(analog_in_connect), .analog_loopback(analog_loopback));
`default_nettype wire

//--- verification/pcs_highway_model.sv
/* Highway controller model: link clocks, syncs and receive data.
   Assumes the bench calls run_frame; clocks idle low between frames. */
`timescale 1ns/100ps
`default_nettype none
module pcs_highway_model (
   output logic       tx_bit_clock,
   output logic       tx_frame_sync,
   output logic       rx_bit_clock,
   output logic       rx_frame_sync,
   output logic       serial_code_in,
   input  wire logic  code_line,
   output logic [7:0] tx_byte,
   output logic       tx_done
);
   initial begin
      {tx_bit_clock, tx_frame_sync, rx_bit_clock, rx_frame_sync} = 4'h0;
      {serial_code_in, tx_done} = 2'h2;
      tx_byte = 8'h00;
   end
   // ------------
   // Frame
   // ------------
   // Ninth clock lets the port release the line
   task automatic run_frame(input logic [7:0] rx_byte);
      logic [7:0] got;
      got = 8'h00;
      #1.7;
      {tx_frame_sync, rx_frame_sync} = 2'h3;
      #32;
      for (int i = 0; i < 9; i++) begin
         if (i > 0) got = {got[6:0], code_line};
         {tx_bit_clock, rx_bit_clock} = 2'h3;
         // Bit period scaled down for short runs; the port is rate blind
         #16;
         serial_code_in = (i < 8) ? rx_byte[7 - i] : ~serial_code_in;
         #16;
         {tx_bit_clock, rx_bit_clock} = 2'h0;
         if (i == 0) {tx_frame_sync, rx_frame_sync} = 2'h0;
         #32;
      end
      tx_byte = got;
      tx_done = 1'b1;
      #4;
      tx_done = 1'b0;
   endtask : run_frame
endmodule : pcs_highway_model
`default_nettype wire

//--- verification/tb_pcs_serial_port.sv
/* Self-checking bench for pcs_serial_port.
   Assumes the highway model drives the link clocks, syncs and receive data; the bench drives power-down and test select. */
`timescale 1ns/100ps
`default_nettype none
module tb_pcs_serial_port;
   localparam int unsigned PDN_N  = 50;
   localparam int unsigned IDLE_N = 400;
   logic clk, rst_n, tx_bit_clock, tx_frame_sync, rx_bit_clock, rx_frame_sync;
   logic serial_code_in, powerdown_halfbit_shift, loopback_test_select, acc;
   logic serial_code_out_o, serial_code_out_oe, enc_valid, enc_ready, watch;
   logic dec_half_shift, dec_valid, tx_powered_down, rx_powered_down, tx_done;
   logic chip_powered_down, analog_out_enable, analog_in_connect, analog_loopback;
   logic [7:0] enc_code, dec_code, tx_byte, b;
   logic [8:0] tx_exp[$], rx_exp[$];
   int         errors, tests_run;
   wire logic  code_line;
   // Pull-up: low only while the port pulls
   assign code_line = serial_code_out_oe ? serial_code_out_o : 1'b1;
   pcs_serial_port #(.LAW(pcs_pkg::PCS_LAW_A), .PDN_CYCLES(PDN_N), .IDLE_CYCLES(IDLE_N),
      .FIFO_DEPTH(4)) dut_u (.clk(clk), .rst_n(rst_n), .tx_bit_clock(tx_bit_clock),
      .tx_frame_sync(tx_frame_sync), .rx_bit_clock(rx_bit_clock),
      .rx_frame_sync(rx_frame_sync), .serial_code_in(serial_code_in),
      .powerdown_halfbit_shift(powerdown_halfbit_shift),
      .loopback_test_select(loopback_test_select), .serial_code_out_o(serial_code_out_o),
      .serial_code_out_oe(serial_code_out_oe), .enc_code(enc_code), .enc_valid(enc_valid),
      .enc_ready(enc_ready), .dec_code(dec_code), .dec_half_shift(dec_half_shift),
      .dec_valid(dec_valid), .tx_powered_down(tx_powered_down),
      .rx_powered_down(rx_powered_down), .chip_powered_down(chip_powered_down),
      .analog_out_enable(analog_out_enable), .analog_in_connect(analog_in_connect),
      .analog_loopback(analog_loopback));
   pcs_highway_model model_u (.tx_bit_clock(tx_bit_clock), .tx_frame_sync(tx_frame_sync),
      .rx_bit_clock(rx_bit_clock), .rx_frame_sync(rx_frame_sync),
      .serial_code_in(serial_code_in), .code_line(code_line), .tx_byte(tx_byte),
      .tx_done(tx_done));
   // ------------
   // Tasks
   // ------------
   task automatic check(input logic [8:0] seen, input logic [8:0] exp);
      tests_run++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic final_report();
      if (errors == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : final_report
   // Gap keeps each frame well inside the idle limit
   task automatic frame(input logic [7:0] v);
      model_u.run_frame(v);
      repeat (60) @(negedge clk);
   endtask : frame
   // ------------
   // Processes
   // ------------
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   initial begin
      #200us;
      errors++;
      final_report();
   end
   // Mid-cycle look: the strobe is launched on the rising edge
   always @(negedge clk) begin
      if (watch && dec_valid === 1'b1) begin
         check({dec_half_shift, dec_code}, (rx_exp.size() > 0) ? rx_exp.pop_front() : 9'h1FF);
      end
   end
   always @(posedge tx_done) begin
      if (watch) begin
         check({1'b0, tx_byte}, (tx_exp.size() > 0) ? tx_exp.pop_front() : 9'h1FF);
      end
   end
   initial begin
      {rst_n, enc_valid, watch, powerdown_halfbit_shift, loopback_test_select} = 5'h03;
      enc_code = 8'h00;
      errors = 0;
      tests_run = 0;
      void'($urandom(54));
      repeat (12) @(negedge clk);
      check(9'({tx_powered_down, rx_powered_down, serial_code_out_oe}), 9'h6);
      rst_n = 1'b1;
      for (int k = 0; k < 20 && {tx_powered_down, rx_powered_down} !== 2'b00; k++) frame(8'h00);
      check(9'({tx_powered_down, rx_powered_down}), 9'h0);
      check(9'({analog_loopback, analog_out_enable, analog_in_connect}), 9'h3);
      watch = 1'b1;
      enc_valid = 1'b1;
      for (int i = 0; i < 5; i++) begin
         enc_code = (i == 0) ? pcs_pkg::ALAW_POS_FULL :
            (i == 1) ? pcs_pkg::ALAW_NEG_FULL : 8'($urandom);
         acc = enc_ready;
         check(9'(acc), 9'(i < 4));
         if (acc === 1'b1) tx_exp.push_back({1'b0, enc_code});
         @(negedge clk);
      end
      enc_valid = 1'b0;
      repeat (2) tx_exp.push_back({1'b0, pcs_pkg::ALAW_POS_ZERO});
      for (int i = 0; i < 6; i++) begin
         b = 8'($urandom);
         rx_exp.push_back({1'b0, b});
         frame(b);
      end
      check(9'(code_line), 9'h1);
      check(9'(rx_exp.size() + tx_exp.size()), 9'h0);
      loopback_test_select = 1'b0;
      repeat (10) @(negedge clk);
      check(9'({analog_loopback, analog_out_enable, analog_in_connect}), 9'h4);
      loopback_test_select = 1'b1;
      powerdown_halfbit_shift = 1'b0;
      repeat (PDN_N / 2) @(negedge clk);
      powerdown_halfbit_shift = 1'b1;
      repeat (10) @(negedge clk);
      check(9'(chip_powered_down), 9'h0);
      powerdown_halfbit_shift = 1'b0;
      repeat (PDN_N + 10) @(negedge clk);
      check(9'(chip_powered_down), 9'h1);
      powerdown_halfbit_shift = 1'b1;
      repeat (IDLE_N) @(negedge clk);
      check(9'({tx_powered_down, rx_powered_down}), 9'h3);
      final_report();
   end
endmodule : tb_pcs_serial_port
`default_nettype wire
